// [rtl/rpd_regs.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  rotor position detector. Included by the detector and its helpers.
*/
`ifndef RPD_REGS_SVH
`define RPD_REGS_SVH

// Byte offsets on the APB slave
`define OFS_DETECT_CONTROL_A 8'h00
`define OFS_SAMPLING_SETUP 8'h04
`define OFS_DETECT_STATUS 8'h08
`define OFS_MOTOR_OUTPUT 8'h0C
`define OFS_SAMPLE_DELAY 8'h10

// detect_control_a fields
`define CA_SW_STOP 7
`define CA_SW_START 6
`define CA_TIMER3_STOP 5
`define CA_TIMER2_START 4
`define CA_ONE_PIN 3
`define CA_RECOUNT 2
`define CA_CHANGE_MODE 1
`define CA_ENABLE 0

// sampling_setup fields
`define SB_PERIOD_HI 7
`define SB_PERIOD_LO 6
`define SB_GATING_HI 5
`define SB_GATING_LO 4
`define SB_COUNT_HI 3
`define SB_COUNT_LO 0

// detect_status fields
`define ST_EDGE_HI 5
`define ST_EDGE_LO 4
`define ST_ACTIVE 3
`define ST_SNAP_HI 2
`define ST_SNAP_LO 0

// Reset values
`define RST_CONTROL_A 8'h00
`define RST_SETUP 8'h00
`define RST_MOTOR_OUTPUT 3'h0
`define RST_SAMPLE_DELAY 8'h00

// Sampling period in system clocks for period selects 0..3
`define PERIOD_DIV4 6'd4
`define PERIOD_DIV8 6'd8
`define PERIOD_DIV16 6'd16
`define PERIOD_DIV32 6'd32

`endif

// [rtl/rpd_pkg.sv]
/*
  Types shared by the rotor position detector files.
  Assumes nothing of its surroundings.
*/
package rpd_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SAMPLING = 1'b1
  } samp_state_t;

  typedef enum logic [1:0] {
    GATE_PWM_ON = 2'b00,
    GATE_REGULAR = 2'b01,
    GATE_LOWER_ON = 2'b10,
    GATE_RESERVED = 2'b11
  } gating_t;

endpackage : rpd_pkg

// [rtl/phase_sync.sv]
/*
  Two-stage synchroniser for a bundle of asynchronous levels.
  Assumes one clock, asynchronous active-high reset and a clock enable.
*/
module phase_sync
#(
  parameter int WIDTH = 3
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb
  begin
    nxt_meta = ce_i ? async_i : meta_ff;
    nxt_sync = ce_i ? meta_ff : sync_ff;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff;
endmodule : phase_sync

// [rtl/sample_tick.sv]
/*
  Sampling period generator: one-cycle tick every 4, 8, 16 or 32 clocks.
  Assumes one clock, asynchronous active-high reset and a clock enable.
*/
`include "rpd_regs.svh"
module sample_tick
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [1:0] period_sel_i,
  output logic tick_o
);
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [5:0] period;

  always_comb
  begin
    case (period_sel_i)
      2'h0: period = `PERIOD_DIV4;
      2'h1: period = `PERIOD_DIV8;
      2'h2: period = `PERIOD_DIV16;
      default: period = `PERIOD_DIV32;
    endcase
    // A period change applies to the running count at once; a count already at or past the new end ticks in the same cycle
    tick_o = (cnt_ff >= period - 6'd1);
    nxt_cnt = cnt_ff;
    if (ce_i)
      nxt_cnt = tick_o ? 6'd0 : cnt_ff + 6'd1;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      cnt_ff <= 6'd0;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule : sample_tick

// [rtl/rotor_position_detector.sv]
/*
  Rotor position detector with APB register slave: samples three phase
  inputs, compares with an expected pattern, pulses an event on detection.
  Assumes PWM, lower-side conduction and timer triggers synchronous to clk_i.
*/
// Implementation choices: the register offsets and register access over APB.
// Function
// - compare sampled phases with expected pattern
// - ordinary mode: match detects and ends sampling
// - unmatch mode: detect change from start snapshot
// - start snapshot readable, bits W V U
// - timer 2 starts, timer 3 stops sampling
// - three sampling gating modes by two bits
// - lower mode samples after delay until off
// - idle phases keep last sample, still compared
// - hold off sampling after turn-on delay
// - optional recount per PWM-on interval
// - edge flags record detection at PWM edges
// - status bit shows sampling active
// - sampling period fc divided 4 to 32
// - ordinary mode needs count consecutive matches
// - unmatch mode needs count consecutive mismatches
// - enable bit starts sampling, clear disables
// - mode bit: 0 ordinary, 1 unmatch
// - gating codes 00 PWM, 01 regular, 10 lower
// - count 0 and 1 both mean one
`include "rpd_regs.svh"
module rotor_position_detector
  import rpd_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic phase_u_input_i,
  input wire logic phase_v_input_i,
  input wire logic phase_w_input_i,
  input wire logic [2:0] pwm_on_i,
  input wire logic [2:0] lower_on_i,
  input wire logic timer2_trig_i,
  input wire logic timer3_trig_i,
  output logic position_detect_irq_o
);
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] setup_ff, nxt_setup;
  logic [2:0] expect_ff, nxt_expect;
  logic [7:0] delay_ff, nxt_delay;
  logic [31:0] rdata_ff, nxt_rdata;
  samp_state_t state_ff, nxt_state;
  logic [2:0] samp_ff, nxt_samp;
  logic [2:0] snap_ff, nxt_snap;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [1:0] edge_ff, nxt_edge;
  logic seen_ff, nxt_seen;
  logic pwm_prev_ff, en_prev_ff, irq_ff;
  logic [2:0] ph;
  logic [3:0] gate_src;
  logic [3:0] gate_ok;
  logic [2:0] g;
  logic [2:0] eff;
  logic [2:0] mask;
  logic [3:0] target;
  gating_t gating;
  logic tick, tick_raw, wr, setup_rd, mapped, active;
  logic pwm_any, pwm_rise, pwm_fall, sw_start, sw_stop;
  logic start_go, stop_req, cmp_tick, cond, detect;

  phase_sync #(.WIDTH(3)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .async_i({phase_w_input_i, phase_v_input_i, phase_u_input_i}),
    .sync_o(ph)
  );

  sample_tick u_tick (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .period_sel_i(setup_ff[`SB_PERIOD_HI:`SB_PERIOD_LO]),
    .tick_o(tick_raw)
  );

  assign tick = tick_raw & ce_i;
  assign gating = gating_t'(setup_ff[`SB_GATING_HI:`SB_GATING_LO]);
  assign active = (state_ff == ST_SAMPLING);
  assign pwm_any = |pwm_on_i;
  assign pwm_rise = pwm_any & ~pwm_prev_ff;
  assign pwm_fall = ~pwm_any & pwm_prev_ff;

  // APB slave: zero wait states while ce_i is high, read data captured in the setup cycle
  assign wr = psel_i & penable_i & pwrite_i & ce_i;
  assign setup_rd = psel_i & ~penable_i & ~pwrite_i & ce_i;
  assign pready_o = ce_i;
  assign mapped = (paddr_i == `OFS_DETECT_CONTROL_A)
    || (paddr_i == `OFS_SAMPLING_SETUP) || (paddr_i == `OFS_DETECT_STATUS)
    || (paddr_i == `OFS_MOTOR_OUTPUT) || (paddr_i == `OFS_SAMPLE_DELAY);
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o = rdata_ff;
  assign sw_start = wr && paddr_i == `OFS_DETECT_CONTROL_A
    && pwdata_i[`CA_SW_START];
  assign sw_stop = wr && paddr_i == `OFS_DETECT_CONTROL_A
    && pwdata_i[`CA_SW_STOP];

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_setup = setup_ff;
    nxt_expect = expect_ff;
    nxt_delay = delay_ff;
    nxt_rdata = rdata_ff;
    if (wr)
    begin
      case (paddr_i)
        // Start and stop strobes are write-only and never stored
        `OFS_DETECT_CONTROL_A: nxt_ctrl = {2'b00, pwdata_i[5:0]};
        `OFS_SAMPLING_SETUP: nxt_setup = pwdata_i[7:0];
        `OFS_MOTOR_OUTPUT: nxt_expect = pwdata_i[2:0];
        `OFS_SAMPLE_DELAY: nxt_delay = pwdata_i[7:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (setup_rd)
    begin
      case (paddr_i)
        `OFS_DETECT_CONTROL_A: nxt_rdata = {24'h0, ctrl_ff};
        `OFS_SAMPLING_SETUP: nxt_rdata = {24'h0, setup_ff};
        // active flag, snapshot W V U
        `OFS_DETECT_STATUS: nxt_rdata = {26'h0, edge_ff, active, snap_ff};
        `OFS_MOTOR_OUTPUT: nxt_rdata = {29'h0, expect_ff};
        `OFS_SAMPLE_DELAY: nxt_rdata = {24'h0, delay_ff};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_ff <= `RST_CONTROL_A;
      setup_ff <= `RST_SETUP;
      expect_ff <= `RST_MOTOR_OUTPUT;
      delay_ff <= `RST_SAMPLE_DELAY;
      rdata_ff <= 32'h0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      setup_ff <= nxt_setup;
      expect_ff <= nxt_expect;
      delay_ff <= nxt_delay;
      rdata_ff <= nxt_rdata;
    end
  end

  // turn-on delay: entries 0..2 lower side, entry 3 any PWM on
  assign gate_src = {pwm_any, lower_on_i};
  for (genvar i = 0; i < 4; i++)
  begin : g_delay
    logic [7:0] dcnt_ff;
    logic [7:0] nxt_dcnt;
    always_comb
    begin
      nxt_dcnt = dcnt_ff;
      if (ce_i)
      begin
        if (!gate_src[i])
          nxt_dcnt = 8'h00;
        else if (dcnt_ff < delay_ff)
          nxt_dcnt = dcnt_ff + 8'h01;
      end
    end
    always_ff @(posedge clk_i or posedge reset_i)
    begin
      if (reset_i)
        dcnt_ff <= 8'h00;
      else
        dcnt_ff <= nxt_dcnt;
    end
    assign gate_ok[i] = gate_src[i] && (dcnt_ff >= delay_ff);
  end

  // per-phase gate; lower mode samples from delay to turn-off
  always_comb
  begin
    case (gating)
      GATE_PWM_ON: g = {3{gate_ok[3]}};
      GATE_REGULAR: g = 3'b111;
      GATE_LOWER_ON: g = gate_ok[2:0];
      default: g = 3'b000;
    endcase
  end

  // idle phases compare with their retained sample
  assign eff = (g & ph) | (~g & samp_ff);
  assign mask = ctrl_ff[`CA_ONE_PIN] ? 3'b001 : 3'b111;
  // count of zero behaves as one
  assign target = (setup_ff[`SB_COUNT_HI:`SB_COUNT_LO] == 4'h0) ? 4'h1
    : setup_ff[`SB_COUNT_HI:`SB_COUNT_LO];
  assign cmp_tick = tick & active & (|g);
  // match against pattern, or change from snapshot
  assign cond = ctrl_ff[`CA_CHANGE_MODE]
    ? ((eff & mask) != (snap_ff & mask))
    : ((eff & mask) == (expect_ff & mask));
  assign detect = cmp_tick & cond & (cnt_ff + 4'h1 >= target);

  // enable rise, software or timer 2 starts sampling
  assign start_go = ce_i && ctrl_ff[`CA_ENABLE] && (state_ff == ST_IDLE)
    && ((ctrl_ff[`CA_ENABLE] && !en_prev_ff) || sw_start
    || (ctrl_ff[`CA_TIMER2_START] && timer2_trig_i));
  // timer 3 or software stops; clearing enable stops
  assign stop_req = sw_stop || !ctrl_ff[`CA_ENABLE]
    || (ctrl_ff[`CA_TIMER3_STOP] && timer3_trig_i);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_samp = samp_ff;
    nxt_snap = snap_ff;
    nxt_cnt = cnt_ff;
    nxt_edge = edge_ff;
    nxt_seen = seen_ff;
    if (ce_i)
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (start_go)
          begin
            nxt_state = ST_SAMPLING;
            nxt_snap = ph;
            nxt_samp = ph;
            nxt_cnt = 4'h0;
            nxt_seen = 1'b0;
            nxt_edge = 2'b00;
          end
        end
        ST_SAMPLING:
        begin
          if (cmp_tick)
          begin
            nxt_samp = eff;
            nxt_cnt = cond ? cnt_ff + 4'h1 : 4'h0;
          end
          // restart the count at each PWM-off
          if (ctrl_ff[`CA_RECOUNT] && gating != GATE_REGULAR && pwm_fall)
            nxt_cnt = 4'h0;
          if (detect || stop_req)
          begin
            nxt_state = ST_IDLE;
            nxt_cnt = 4'h0;
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
      if (detect)
        nxt_seen = 1'b1;
      // record detection at falling and rising PWM edges
      if (pwm_fall)
        nxt_edge[1] = seen_ff | detect;
      if (pwm_rise)
        nxt_edge[0] = seen_ff | detect;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_ff <= ST_IDLE;
      samp_ff <= 3'h0;
      snap_ff <= 3'h0;
      cnt_ff <= 4'h0;
      edge_ff <= 2'b00;
      seen_ff <= 1'b0;
      pwm_prev_ff <= 1'b0;
      en_prev_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      samp_ff <= nxt_samp;
      snap_ff <= nxt_snap;
      cnt_ff <= nxt_cnt;
      edge_ff <= nxt_edge;
      seen_ff <= nxt_seen;
      if (ce_i)
      begin
        pwm_prev_ff <= pwm_any;
        en_prev_ff <= ctrl_ff[`CA_ENABLE];
        irq_ff <= detect;
      end
    end
  end

  // Registered so the event pulse is glitch free
  assign position_detect_irq_o = irq_ff;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  detect_ends_session_a: assert property (detect |=> !active)
    else $error("sampling still active after detection");
  irq_follows_a: assert property (detect |=> position_detect_irq_o)
    else $error("detection event not pulsed");
  count_reached_a: assert property (detect |-> cnt_ff == target - 4'h1)
    else $error("detection before the consecutive count");
  snapshot_taken_a: assert property (start_go |=> snap_ff == $past(ph))
    else $error("start snapshot not latched");
  timer_start_a: assert property (
    (!active && ctrl_ff[0] && en_prev_ff && ctrl_ff[4] && timer2_trig_i
    && ce_i) |=> active)
    else $error("timer 2 trigger did not start sampling");
  enable_clear_a: assert property (
    (!ctrl_ff[0] && ce_i) |=> !active)
    else $error("sampling continues while disabled");
  idle_hold_a: assert property (
    (active && gating == GATE_LOWER_ON && !g[0] && ce_i && !start_go)
    |=> samp_ff[0] == $past(samp_ff[0]))
    else $error("idle phase sample changed");
  recount_a: assert property (
    (active && ctrl_ff[2] && gating == GATE_PWM_ON && pwm_fall && ce_i)
    |=> cnt_ff == 4'h0)
    else $error("count not restarted at PWM off");
  reserved_gate_a: assert property (
    gating == GATE_RESERVED |-> !detect)
    else $error("reserved gating sampled");
endmodule : rotor_position_detector

// [dv/hall_sensor_model.sv]
/*
  Model of the Hall sensor outputs feeding the three phase inputs.
  Assumes the bench sets the wanted level pattern, W V U order.
*/
module hall_sensor_model
(
  input wire logic clk_i,
  input wire logic [2:0] level_i,
  output logic phase_u_o,
  output logic phase_v_o,
  output logic phase_w_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sensor edges are driven on the falling edge of clk_i, so they land mid-cycle
  always @(negedge clk_i)
  begin
    phase_u_o <= level_i[0];
    phase_v_o <= level_i[1];
    phase_w_o <= level_i[2];
  end
endmodule : hall_sensor_model

// [dv/rotor_position_detector_test.sv]
/*
  Self-checking bench of the rotor position detector over APB.
  Assumes the design answers APB with pready and a 50 MHz clock.
*/
`include "rpd_regs.svh"
module rotor_position_detector_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_i, psel, penable, pwrite, pready, pslverr, irq;
  logic u, v, w, t2, t3, ce;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] hall, pwm, lower;
  int fail_count = 0;
  int check_count = 0;
  int irq_total = 0;

  rotor_position_detector rotor_position_detector_inst
  (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .phase_u_input_i(u), .phase_v_input_i(v),
    .phase_w_input_i(w), .pwm_on_i(pwm), .lower_on_i(lower),
    .timer2_trig_i(t2), .timer3_trig_i(t3),
    .position_detect_irq_o(irq)
  );

  hall_sensor_model hall_sensor_model_inst
  (
    .clk_i(clk_i), .level_i(hall), .phase_u_o(u), .phase_v_o(v),
    .phase_w_o(w)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
    if (irq === 1'b1)
      irq_total++;

  task finish_test;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Request held until pready is sampled high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do
      @(posedge clk_i);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask : wr

  task rd_chk(input string nm, input logic [7:0] a, input logic [7:0] m,
              input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(nm, {24'h0, exp}, r & {24'h0, m});
  endtask : rd_chk

  task start(input logic [7:0] setup, input logic [7:0] ctrl);
    wr(`OFS_DETECT_CONTROL_A, 8'h00);
    wr(`OFS_SAMPLING_SETUP, setup);
    wr(`OFS_DETECT_CONTROL_A, ctrl);
  endtask : start

  // No pulse in the first quiet cycles; one by limit if exp
  task irq_window(input string nm, input int quiet, input int limit,
                  input logic exp);
    int first;
    first = -1;
    for (int i = 0; i < limit; i++)
    begin
      @(posedge clk_i);
      if (irq === 1'b1 && first < 0)
        first = i;
    end
    check({nm, " early"}, 32'h0, {31'h0, first >= 0 && first < quiet});
    check({nm, " seen"}, {31'h0, exp}, {31'h0, first >= 0});
  endtask : irq_window

  task test_regs;
    logic [31:0] r;
    logic e;
    rd_chk("control", `OFS_DETECT_CONTROL_A, 8'hFF, 8'h00);
    rd_chk("setup", `OFS_SAMPLING_SETUP, 8'hFF, 8'h00);
    rd_chk("status", `OFS_DETECT_STATUS, 8'hFF, 8'h00);
    apb(1'b0, 8'h20, 32'h0, r, e);
    check("unmapped err", 32'h1, {31'h0, e});
    wr(`OFS_SAMPLING_SETUP, 8'hA5);
    rd_chk("setup rw", `OFS_SAMPLING_SETUP, 8'hFF, 8'hA5);
    wr(`OFS_DETECT_CONTROL_A, 8'hC2);
    rd_chk("pulse bits", `OFS_DETECT_CONTROL_A, 8'hFF, 8'h02);
  endtask : test_regs

  task test_ordinary;
    hall <= 3'b101;
    wr(`OFS_MOTOR_OUTPUT, 8'h05);
    start(8'h10, 8'h01);
    irq_window("ordinary", 0, 100, 1'b1);
    rd_chk("ended", `OFS_DETECT_STATUS, 8'h08, 8'h00);
    irq_window("rearm", 0, 100, 1'b0);
  endtask : test_ordinary

  // Clock enable low must hold off the pending start and stall the bus
  task test_freeze;
    hall <= 3'b101;
    start(8'h10, 8'h01);
    ce <= 1'b0;
    irq_window("frozen", 0, 40, 1'b0);
    check("stall pready", 32'h0, {31'h0, pready});
    ce <= 1'b1;
    irq_window("thawed", 0, 100, 1'b1);
  endtask : test_freeze

  task test_period;
    for (int s = 0; s < 4; s++)
    begin
      start({s[1:0], 6'h12}, 8'h01);
      irq_window("period", 4 << s, 12 << s, 1'b1);
    end
  endtask : test_period

  task test_count;
    hall <= 3'b010;
    start(8'h14, 8'h01);
    irq_window("mismatch", 0, 60, 1'b0);
    hall <= 3'b101;
    irq_window("count", 14, 60, 1'b1);
  endtask : test_count

  task test_unmatch;
    hall <= 3'b110;
    start(8'h11, 8'h03);
    rd_chk("snapshot", `OFS_DETECT_STATUS, 8'hFF, 8'h0E);
    irq_window("steady", 0, 40, 1'b0);
    hall <= 3'b100;
    irq_window("change", 0, 40, 1'b1);
  endtask : test_unmatch

  task test_timer;
    hall <= 3'b010;
    start(8'h11, 8'h31);
    rd_chk("enabled", `OFS_DETECT_STATUS, 8'h08, 8'h08);
    t3 <= 1'b1;
    @(posedge clk_i);
    t3 <= 1'b0;
    rd_chk("timer stop", `OFS_DETECT_STATUS, 8'h08, 8'h00);
    t2 <= 1'b1;
    @(posedge clk_i);
    t2 <= 1'b0;
    rd_chk("timer start", `OFS_DETECT_STATUS, 8'h08, 8'h08);
    wr(`OFS_DETECT_CONTROL_A, 8'hB1);
    rd_chk("sw stop", `OFS_DETECT_STATUS, 8'h08, 8'h00);
    wr(`OFS_DETECT_CONTROL_A, 8'h71);
    rd_chk("sw start", `OFS_DETECT_STATUS, 8'h08, 8'h08);
    wr(`OFS_DETECT_CONTROL_A, 8'h00);
    rd_chk("disable", `OFS_DETECT_STATUS, 8'h08, 8'h00);
  endtask : test_timer

  task test_gating;
    int n;
    hall <= 3'b101;
    wr(`OFS_SAMPLE_DELAY, 8'h08);
    start(8'h00, 8'h01);
    irq_window("pwm off", 0, 60, 1'b0);
    pwm <= 3'b111;
    irq_window("pwm on", 8, 80, 1'b1);
    pwm <= 3'b000;
    rd_chk("fall flag", `OFS_DETECT_STATUS, 8'h38, 8'h20);
    start(8'h21, 8'h01);
    irq_window("lower off", 0, 60, 1'b0);
    lower <= 3'b111;
    irq_window("lower on", 8, 80, 1'b1);
    start(8'h31, 8'h01);
    pwm <= 3'b111;
    irq_window("reserved", 0, 80, 1'b0);
    lower <= 3'b000;
    for (int k = 0; k < 2; k++)
    begin
      pwm <= 3'b000;
      start(8'h04, k ? 8'h01 : 8'h05);
      n = irq_total;
      repeat (10)
      begin
        pwm <= 3'b111;
        repeat (16) @(posedge clk_i);
        pwm <= 3'b000;
        repeat (4) @(posedge clk_i);
      end
      check("recount", {31'h0, k[0]}, {31'h0, irq_total > n});
    end
  endtask : test_gating

  initial
  begin
    reset_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hall = 3'b000;
    pwm = 3'b000;
    lower = 3'b000;
    t2 = 1'b0;
    t3 = 1'b0;
    ce = 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    test_regs();
    test_ordinary();
    test_freeze();
    test_period();
    test_count();
    test_unmatch();
    test_timer();
    test_gating();
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end
endmodule : rotor_position_detector_test
